//--- hw/ofr_fault_response.sv
// Purpose : Undervoltage response and peak overcurrent check, one output.
// Assumes : Commands arrive already decoded from the PMBus engine.
// Notes   : Samples are signed fixed point with FRAC fraction bits.
`include "ofr_cfg.svh"
module ofr_fault_response
	import ofr_pkg::*;
#(
	parameter int TICK_CYCLES = `OFR_TICK_CYCLES,
	parameter int FRAC        = 4,
	parameter int CNT_W       = 4
)(
	// Clock and reset.
	input  wire logic               i_clock,
	input  wire logic               i_reset_n,
	// Decoded command port.
	input  wire logic               i_cmd_valid,
	input  wire logic               i_cmd_write,
	input  wire logic [7:0]         i_cmd_code,
	input  wire logic [15:0]        i_cmd_data,
	output logic      [15:0]        o_read_data,
	// Pins: strap value and enable pin.
	input  wire logic [15:0]        i_strap_oc_limit,
	input  wire logic               i_enable_pin,
	// Same-domain conditions from the rest of the controller.
	input  wire logic               i_operation_on,
	input  wire logic               i_bias_ok,
	input  wire logic               i_other_fault,
	input  wire logic               i_power_good,
	input  wire logic               i_uv_below,
	// Current sense samples and their qualification.
	input  wire logic               i_sample_valid,
	input  wire logic               i_blank_done,
	input  wire logic signed [15:0] i_sample,
	input  wire logic [CNT_W-1:0]   i_consec_count,
	input  wire logic               i_avg_oc_trip,
	// Outputs to the power stage and host.
	output logic                    o_output_enable,
	output logic                    o_oc_fault,
	output logic                    o_uv_status,
	output logic                    o_oc_status,
	output logic                    o_alert_line_n
);
	// ************************************************************
	// Registers and synchronisers
	// ************************************************************
	logic [7:0]        uv_cfg_reg;      // Response byte.
	logic [15:0]       oc_limit_reg;    // Linear-11 threshold.
	logic [15:0]       strap_s1_reg;    // Strap, first stage.
	logic [15:0]       strap_s2_reg;    // Strap, second stage.
	logic              en_s1_reg;       // Enable pin, first stage.
	logic              en_s2_reg;       // Enable pin, second stage.
	logic [1:0]        strap_cnt_reg;   // Waits out the synchroniser.
	logic              strap_done_reg;  // Strap value taken.
	ofr_state_t        state_reg;       // Output control state.
	ofr_state_t        state_next;      // Next output control state.
	logic [13:0]       tick_cnt_reg;    // Cycle divider to 1 ms.
	logic [8:0]        ms_cnt_reg;      // Ms since attempt start.
	logic              attempt_reg;     // Inside a retry sequence.
	logic [CNT_W-1:0]  oc_cnt_reg;      // Consecutive over samples.
	logic              uv_stat_reg;     // Sticky undervoltage bit.
	logic              oc_stat_reg;     // Sticky overcurrent bit.
	logic              oc_fault_reg;    // Trip response, one cycle late.
	logic [15:0]       rd_reg;          // Read data holder.

	// ************************************************************
	// Decode
	// ************************************************************
	// Command strobes.
	wire wr_uv  = i_cmd_valid && i_cmd_write
		&& i_cmd_code == `OFR_CMD_UV_RESP;
	wire wr_oc  = i_cmd_valid && i_cmd_write
		&& i_cmd_code == `OFR_CMD_OC_LIMIT;
	wire clr    = i_cmd_valid && i_cmd_write
		&& i_cmd_code == `OFR_CMD_CLR_FAULTS;
	wire rd     = i_cmd_valid && !i_cmd_write;
	// Response byte fields.
	wire [1:0] resp  = uv_cfg_reg[`OFR_RESP_HI:`OFR_RESP_LO];
	wire [2:0] retry = uv_cfg_reg[`OFR_RETRY_HI:`OFR_RETRY_LO];
	wire [2:0] delay = uv_cfg_reg[`OFR_DELAY_HI:`OFR_DELAY_LO];
	// Codes 1x shut down; codes 00 and 01 only flag.
	wire shut_mode   = resp[1];
	wire retry_on    = retry == `OFR_RETRY_ALWAYS;
	// Retry interval in ms, 35 to 280.
	wire [8:0] target_ms = 9'(({6'h00, delay} + 9'h001)
		* 9'(`OFR_RETRY_UNIT_MS));
	// The output may run at all.
	wire run_ok = en_s2_reg && i_operation_on && i_bias_ok
		&& !i_other_fault;
	// Undervoltage event is masked until power good.
	wire uv_event = i_uv_below && i_power_good
		&& state_reg == OFR_ST_ON;
	wire ms_tick  = tick_cnt_reg == 14'(TICK_CYCLES - 1);
	wire restart  = state_reg == OFR_ST_WAIT && run_ok
		&& ms_cnt_reg >= target_ms;
	// Linear-11 decode of the threshold.
	wire signed [4:0]  lin_exp  =
		oc_limit_reg[`OFR_EXP_HI:`OFR_EXP_LO];
	wire signed [10:0] lin_mant =
		oc_limit_reg[`OFR_MANT_HI:`OFR_MANT_LO];
	wire signed [6:0]  shift    = 7'(lin_exp) + 7'(FRAC);
	wire signed [31:0] mant_w   = 32'(lin_mant);
	// Threshold scaled into the sample's fixed point.
	wire signed [31:0] limit_fx = shift[6] ?
		(mant_w >>> 5'(-shift)) : (mant_w <<< 5'(shift));
	// Samples are compared only once blanking has ended.
	wire sample_qual = i_sample_valid && i_blank_done;
	wire over        = 32'(i_sample) > limit_fx;
	// One spare bit keeps the run count from wrapping in the compare.
	wire peak_trip   = sample_qual && over
		&& ({1'b0, oc_cnt_reg} + 1'b1)
		>= {1'b0, i_consec_count};
	// Peak and average trips feed one status and one response.
	wire oc_event    = peak_trip || i_avg_oc_trip;

	// ************************************************************
	// Output control state machine
	// ************************************************************
	// Chooses the next state from faults, clear and run conditions.
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			OFR_ST_ON:
			begin
				// Commanded off or forced down.
				if (!run_ok)
					state_next = OFR_ST_OFF;
				else if (uv_event && shut_mode)
					state_next = retry_on ? OFR_ST_WAIT
						: OFR_ST_LATCHED;
			end
			OFR_ST_WAIT:
			begin
				// Retrying stops on off, bias loss or other fault.
				if (!run_ok)
					state_next = OFR_ST_OFF;
				else if (restart)
					state_next = OFR_ST_ON;
			end
			OFR_ST_LATCHED:
			begin
				// Held off until the fault is cleared.
				if (clr)
					state_next = run_ok ? OFR_ST_ON : OFR_ST_OFF;
			end
			OFR_ST_OFF:
			begin
				// A fresh enable restarts the output.
				if (run_ok)
					state_next = OFR_ST_ON;
			end
			default:
				state_next = OFR_ST_OFF;
		endcase
	end

	// ************************************************************
	// Clocked state
	// ************************************************************
	// Synchronisers for the strap and enable pins.
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			strap_s1_reg <= 16'h0000;
			strap_s2_reg <= 16'h0000;
			en_s1_reg    <= 1'b0;
			en_s2_reg    <= 1'b0;
		end
		else
		begin
			strap_s1_reg <= i_strap_oc_limit;
			strap_s2_reg <= strap_s1_reg;
			en_s1_reg    <= i_enable_pin;
			en_s2_reg    <= en_s1_reg;
		end
	end

	// Configuration registers; the threshold loads from the strap.
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			uv_cfg_reg     <= `OFR_UV_RESP_RST;
			oc_limit_reg   <= 16'h0000;
			strap_cnt_reg  <= 2'h0;
			strap_done_reg <= 1'b0;
		end
		else
		begin
			if (wr_uv)
				uv_cfg_reg <= i_cmd_data[7:0];
			if (!strap_done_reg)
				strap_cnt_reg <= strap_cnt_reg + 2'h1;
			if (!strap_done_reg && strap_cnt_reg == 2'h2)
			begin
				oc_limit_reg   <= strap_s2_reg;
				strap_done_reg <= 1'b1;
			end
			else if (wr_oc)
				oc_limit_reg <= i_cmd_data;
		end
	end

	// State, ms divider and attempt timer.
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state_reg    <= OFR_ST_OFF;
			tick_cnt_reg <= 14'h0000;
			ms_cnt_reg   <= 9'h000;
			attempt_reg  <= 1'b0;
		end
		else
		begin
			state_reg    <= state_next;
			tick_cnt_reg <= ms_tick ? 14'h0000 : tick_cnt_reg + 14'h0001;
			// Timer restarts at each attempt and at a first fault.
			if (restart || (state_next == OFR_ST_WAIT
				&& state_reg == OFR_ST_ON && !attempt_reg))
				ms_cnt_reg <= 9'h000;
			else if (ms_tick && ms_cnt_reg != 9'h1FF)
				ms_cnt_reg <= ms_cnt_reg + 9'h001;
			if (restart)
				attempt_reg <= 1'b1;
			else if (state_next == OFR_ST_OFF || clr)
				attempt_reg <= 1'b0;
		end
	end

	// Sticky status, consecutive counter and read data.
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			oc_cnt_reg   <= '0;
			uv_stat_reg  <= 1'b0;
			oc_stat_reg  <= 1'b0;
			oc_fault_reg <= 1'b0;
			rd_reg       <= 16'h0000;
		end
		else
		begin
			// The run count saturates so a long overload keeps tripping.
			if (sample_qual && !over)
				oc_cnt_reg <= '0;
			else if (sample_qual && oc_cnt_reg != '1)
				oc_cnt_reg <= oc_cnt_reg + 1'b1;
			// Set wins over a clear in the same cycle.
			uv_stat_reg  <= uv_event || (uv_stat_reg && !clr);
			oc_stat_reg  <= oc_event || (oc_stat_reg && !clr);
			oc_fault_reg <= oc_event;
			if (rd)
				rd_reg <= i_cmd_code == `OFR_CMD_UV_RESP ?
					{8'h00, uv_cfg_reg} : i_cmd_code == `OFR_CMD_OC_LIMIT
					? oc_limit_reg : 16'h0000;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign o_output_enable = state_reg == OFR_ST_ON;
	assign o_uv_status     = uv_stat_reg;
	assign o_oc_status     = oc_stat_reg;
	assign o_oc_fault      = oc_fault_reg;
	assign o_read_data     = rd_reg;
	assign o_alert_line_n  = !(uv_stat_reg || oc_stat_reg);

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking ck @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);

	uv_pg_gate_a: assert property (
		$rose(uv_stat_reg) |-> $past(i_power_good))
		else $error("Undervoltage flagged without power good.");
	uv_reset_val_a: assert property (
		$past(!i_reset_n) |-> uv_cfg_reg == `OFR_UV_RESP_RST)
		else $error("Response byte left reset wrong.");
	alert_low_a: assert property (
		uv_stat_reg |-> !o_alert_line_n)
		else $error("Alert not low with fault set.");
	uv_sticky_a: assert property (
		uv_stat_reg && !clr |=> uv_stat_reg)
		else $error("Undervoltage bit dropped without clear.");
	no_retry_a: assert property (
		state_reg == OFR_ST_LATCHED && !clr |=> !o_output_enable)
		else $error("Output came back without clear.");
	retry_stop_a: assert property (
		state_reg == OFR_ST_WAIT && !run_ok |=> state_reg == OFR_ST_OFF)
		else $error("Retry did not stop.");
	retry_time_a: assert property (
		state_reg == OFR_ST_WAIT && ms_cnt_reg < target_ms
		|=> !o_output_enable)
		else $error("Restart before retry delay.");
	blank_hold_a: assert property (
		!sample_qual |=> $stable(oc_cnt_reg))
		else $error("Unqualified sample moved counter.");
	oc_shared_a: assert property (
		oc_event |=> oc_stat_reg && o_oc_fault)
		else $error("Overcurrent not flagged.");
	strap_load_a: assert property (
		!strap_done_reg && strap_cnt_reg == 2'h2
		|=> oc_limit_reg == $past(strap_s2_reg))
		else $error("Strap not loaded.");
	retry_seen_c: cover property (restart);
	latched_seen_c: cover property (state_reg == OFR_ST_LATCHED ##1 clr);
	peak_trip_c: cover property (peak_trip);
endmodule : ofr_fault_response

//--- hw/ofr_cfg.svh
// Purpose : Offsets, field positions, reset values and timing counts.
// Assumes : Included by the fault response design file and its test bench.
// Notes   : Definitions only.
`ifndef OFR_CFG_SVH
`define OFR_CFG_SVH
// Command codes of the two registers and of the fault clear command.
`define OFR_CMD_UV_RESP    8'h45
`define OFR_CMD_OC_LIMIT   8'h46
`define OFR_CMD_CLR_FAULTS 8'h03
// Undervoltage response reset value and field positions.
`define OFR_UV_RESP_RST    8'h80
`define OFR_RESP_HI        7
`define OFR_RESP_LO        6
`define OFR_RETRY_HI       5
`define OFR_RETRY_LO       3
`define OFR_DELAY_HI       2
`define OFR_DELAY_LO       0
`define OFR_RETRY_NONE     3'h0
`define OFR_RETRY_ALWAYS   3'h7
// Linear-11 field positions.
`define OFR_EXP_HI         15
`define OFR_EXP_LO         11
`define OFR_MANT_HI        10
`define OFR_MANT_LO        0
// Timing: retry unit in ms, clock in Hz, cycles per ms tick.
`define OFR_RETRY_UNIT_MS  35
`define OFR_CLOCK_HZ       10000000
`define OFR_TICK_MS        1
`define OFR_TICK_CYCLES    (`OFR_CLOCK_HZ / 1000 * `OFR_TICK_MS)
`endif

//--- hw/ofr_pkg.sv
// Purpose : Types shared by the output fault response block.
// Assumes : Nothing.
// Notes   : Timing and layout constants live in ofr_cfg.svh.
package ofr_pkg;
	// Output control state of the undervoltage response.
	typedef enum logic [1:0]
	{
		OFR_ST_ON,
		OFR_ST_WAIT,
		OFR_ST_LATCHED,
		OFR_ST_OFF
	} ofr_state_t;
endpackage : ofr_pkg

//--- tb/ofr_host_model.sv
// Purpose : Command host model for the fault response block.
// Assumes : Commands launch on the falling clock edge, one at a time.
// Notes   : Idle data lines show inverted values; code and write lines keep the last ones.
module ofr_host_model
(
	// Clock and read answer.
	input  wire logic        i_clock,
	input  wire logic [15:0] i_read_data,
	// Command strobe and payload.
	output logic             o_cmd_valid,
	output logic             o_cmd_write,
	output logic [7:0]       o_cmd_code,
	output logic [15:0]      o_cmd_data
);
	timeunit 1ns;
	timeprecision 1ns;
	// The command port idles with the strobe low.
	initial
	begin
		o_cmd_valid = 1'b0;
		o_cmd_write = 1'b0;
		o_cmd_code  = 8'h00;
		o_cmd_data  = 16'h0000;
	end
	// Strobe for one cycle; the answer stands, so it is read a cycle late.
	task automatic xfer(input logic wr, input logic [7:0] code,
		input logic [15:0] data, output logic [15:0] rd);
		@(negedge i_clock);
		o_cmd_valid = 1'b1;
		o_cmd_write = wr;
		o_cmd_code  = code;
		o_cmd_data  = data;
		@(negedge i_clock);
		o_cmd_valid = 1'b0;
		o_cmd_data  = ~data;
		@(negedge i_clock);
		rd = i_read_data;
	endtask : xfer
endmodule : ofr_host_model

//--- tb/tb_output_fault_response_limits.sv
// Purpose : Self-checking bench for the output fault response block.
// Assumes : Retry tick shortened to 10 cycles, so 1 ms is 10 cycles.
// Notes   : Samples carry 4 fraction bits; 10 A is 16'd160.
`include "ofr_cfg.svh"
module tb_output_fault_response_limits;
	timeunit 1ns;
	timeprecision 1ns;
	// ********************************
	// Signals
	// ********************************
	localparam logic [15:0] STRAP = 16'h00C8;
	logic               clock = 1'b0;
	logic               reset_n = 1'b0;
	logic               cmd_valid, cmd_write;
	logic [7:0]         cmd_code;
	logic [15:0]        cmd_data, read_data, rd;
	logic               en_pin = 1'b1, op_on = 1'b1, bias = 1'b1;
	logic               oth = 1'b0, pg = 1'b0, uvb = 1'b0;
	logic               sv = 1'b0, blank = 1'b0, avg = 1'b0;
	logic signed [15:0] smp = 16'sh0000;
	logic [3:0]         consec = 4'h1;
	logic               oe, ocf, uvs, ocs, alert_n, p;
	logic [15:0]        words [2] = '{16'h000A, 16'hF814};
	// The first sample is under the limit so no earlier run carries over.
	logic [15:0]        seq [7] = '{16'h00A0, 16'h00A1, 16'h00A1,
		16'h00A0, 16'h00A1, 16'h00A1, 16'h00A1};
	int                 error_cnt = 0, checks = 0, cyc = 0, n, n2, m;
	// The clock toggles every 50 ns, a period of 100 ns.
	always #50 clock = ~clock;
	ofr_host_model i_host (.i_clock(clock), .i_read_data(read_data),
		.o_cmd_valid(cmd_valid), .o_cmd_write(cmd_write),
		.o_cmd_code(cmd_code), .o_cmd_data(cmd_data));
	ofr_fault_response #(.TICK_CYCLES(10)) i_dut (.i_clock(clock),
		.i_reset_n(reset_n), .i_cmd_valid(cmd_valid),
		.i_cmd_write(cmd_write), .i_cmd_code(cmd_code),
		.i_cmd_data(cmd_data), .o_read_data(read_data),
		.i_strap_oc_limit(STRAP), .i_enable_pin(en_pin),
		.i_operation_on(op_on), .i_bias_ok(bias), .i_other_fault(oth),
		.i_power_good(pg), .i_uv_below(uvb), .i_sample_valid(sv),
		.i_blank_done(blank), .i_sample(smp), .i_consec_count(consec),
		.i_avg_oc_trip(avg), .o_output_enable(oe), .o_oc_fault(ocf),
		.o_uv_status(uvs), .o_oc_status(ocs), .o_alert_line_n(alert_n));
	// ********************************
	// Tasks
	// ********************************
	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Prints the verdict and ends the run.
	task automatic results;
		if (error_cnt == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results
	// Presents one current sample and returns the fault pulse after it.
	task automatic samp(input logic [15:0] v, input logic b);
		@(negedge clock);
		sv = 1'b1;
		blank = b;
		smp = v;
		@(negedge clock);
		sv = 1'b0;
		blank = ~b;
		smp = ~v;
		p = ocf;
	endtask : samp
	// Counts falling edges until the output enable shows v, up to lim.
	task automatic cnt_to(input logic v, input int lim, output int c);
		c = 0;
		while (oe !== v && c < lim)
		begin
			@(negedge clock);
			c++;
		end
	endtask : cnt_to
	// Sends the clear faults command.
	task automatic clear;
		i_host.xfer(1'b1, `OFR_CMD_CLR_FAULTS, 16'h0000, rd);
	endtask : clear
	// A hang is cut short by a cycle ceiling.
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			results();
		end
	end
	// ********************************
	// Main sequence
	// ********************************
	initial
	begin
		repeat (16) @(negedge clock);
		reset_n = 1'b1;
		repeat (4) @(negedge clock);
		i_host.xfer(1'b0, `OFR_CMD_UV_RESP, 16'h0000, rd);
		chk(rd, 16'h0080);
		i_host.xfer(1'b0, `OFR_CMD_OC_LIMIT, 16'h0000, rd);
		chk(rd, STRAP);
		i_host.xfer(1'b0, 8'h47, 16'h0000, rd);
		chk(rd, 16'h0000);
		// Both words mean 10 A, one with exponent 0, one with -1.
		foreach (words[k])
		begin
			i_host.xfer(1'b1, `OFR_CMD_OC_LIMIT, words[k], rd);
			i_host.xfer(1'b0, `OFR_CMD_OC_LIMIT, 16'h0000, rd);
			chk(rd, words[k]);
			samp(16'd161, 1'b0);
			chk(p, 1'b0);
			samp(16'd160, 1'b1);
			chk(p, 1'b0);
			samp(16'd161, 1'b1);
			chk(p, 1'b1);
			chk({ocs, alert_n}, 2'b10);
			clear();
			chk({ocs, alert_n}, 2'b01);
		end
		// An under-limit sample restarts the run of three.
		consec = 4'h3;
		foreach (seq[j])
		begin
			samp(seq[j], 1'b1);
			chk(p, 1'(j == 6));
		end
		clear();
		@(negedge clock);
		avg = 1'b1;
		@(negedge clock);
		avg = 1'b0;
		chk({ocf, ocs}, 2'b11);
		clear();
		// Undervoltage is ignored until power good.
		uvb = 1'b1;
		repeat (4) @(negedge clock);
		chk(uvs, 1'b0);
		pg = 1'b1;
		repeat (3) @(negedge clock);
		chk({uvs, alert_n, oe}, 3'b100);
		uvb = 1'b0;
		cnt_to(1'b1, 500, n);
		chk(n, 500);
		clear();
		cnt_to(1'b1, 10, n);
		chk({oe, uvs, alert_n}, 3'b101);
		// Continuous retry with the shortest and longest delay.
		for (int d = 0; d < 8; d += 7)
		begin
			i_host.xfer(1'b1, `OFR_CMD_UV_RESP,
				{8'h00, (d ? 2'b11 : 2'b10), 3'b111, 3'(d)}, rd);
			uvb = 1'b1;
			m = (d + 1) * 350;
			cnt_to(1'b0, 10, n);
			chk(oe, 1'b0);
			cnt_to(1'b1, 4000, n);
			chk(n >= m - 12 && n <= m + 12, 1'b1);
			cnt_to(1'b0, 10, n);
			cnt_to(1'b1, 4000, n2);
			chk(n + n2 >= m - 12 && n + n2 <= m + 12, 1'b1);
			uvb = 1'b0;
			clear();
			repeat (3) @(negedge clock);
		end
		// Response code 00 only flags the fault; the output stays on.
		i_host.xfer(1'b1, `OFR_CMD_UV_RESP, 16'h0038, rd);
		uvb = 1'b1;
		repeat (3) @(negedge clock);
		chk({uvs, oe}, 2'b11);
		uvb = 1'b0;
		clear();
		chk(uvs, 1'b0);
		// Off command, enable pin, bias loss and another fault each stop
		// retrying; the 35 ms delay would restart well inside 500 cycles.
		i_host.xfer(1'b1, `OFR_CMD_UV_RESP, 16'h00B8, rd);
		for (int q = 0; q < 4; q++)
		begin
			uvb = 1'b1;
			cnt_to(1'b0, 10, n);
			{op_on, en_pin, bias, oth} = 4'b1110 ^ (4'b1000 >> q);
			cnt_to(1'b1, 500, n);
			chk(n, 500);
			{op_on, en_pin, bias, oth} = 4'b1110;
			uvb = 1'b0;
			clear();
			cnt_to(1'b1, 20, n);
			chk(oe, 1'b1);
		end
		results();
	end
endmodule : tb_output_fault_response_limits
